// file: core/tsc_ctrl.sv
/*
 * Teleprinter serial controller: receiver and transmitter sections behind a
 * classic Wishbone slave, each with its own interrupt request line.
 * Assumes rxd and online come from the terminal asynchronously and that the
 * Wishbone master holds each request until it samples ack or err.
 */
// Implementation choices: the placing of the registers and the Wishbone slave port.
// Summary of operation
// [R01] Eleven-unit start-stop frames at 110 baud.
// [R02] Bytes parallel to host, serial to terminal.
// [R03] Transmitter at even station, receiver next odd.
// [R04] Keyboard always accepted online; reader under command.
// [R05] Data-out refused while previous byte serialises.
// [R06] Each section has own mode and request.
// [R07] Reset suppresses requests and inhibits reader.
// [R08] Reset leaves transmitter needing service, request suppressed.
// [R09] Data-out or address-in drops transmitter request.
// [R10] No new request until next byte sent.
// [R11] Inhibit suppresses pending request; allow releases it.
// [R12] Receiver requests per character until served.
// [R13] Unread byte discarded when next character starts.
// [R14] Data-in refused without a valid byte.
// [R15] Transmitter request after eighth data bit.
// [R16] Inhibited receiver: no request, address-in ignored.
// [R17] Inhibited receiver: first data-in takes byte.
// [R18] Inhibited transmitter: no request, address-in ignored.
// [R19] Every valid command word is acknowledged; the transmitter station acknowledges only inhibit and allow.
// [R20] Host sends only the eight valid commands.
// [R21] Keyboard characters carry eighth bit set.
// [R22] Command bits: start, stop, inhibit, allow.
// [R23] Stop reader after one further character.
// [R24] Byte MSB on line eight, LSB line fifteen.
// [R25] Data-in clears receiver request and service.
// [R26] Start, eight data LSB first, two stops.
// [R27] Start found on falling edge, mid-unit sampling.
`timescale 1ns/1ps

module tsc_ctrl
    import tsc_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = BIT_CYCLES_DEF,
    parameter logic [7:0]  STATION    = STATION_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   wb_err_o,
    output logic                   rx_irq,
    output logic                   tx_irq,
    output logic                   txd,
    input  wire logic              rxd,
    input  wire logic              online,
    output logic                   reader_run
);

    localparam logic [CNT_W-1:0] BIT_LOAD  = CNT_W'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] HALF_LOAD = CNT_W'(BIT_CYCLES / 2 - 1);

    // Complete state of the block.
    typedef struct packed {
        logic                   ack;
        logic                   err;
        logic [BYTE_W-1:0]      dat;
        tsc_tx_state_t          tx_st;
        logic [FRAME_UNITS-1:0] tx_shift;
        logic [3:0]             tx_unit;
        logic [CNT_W-1:0]       tx_cnt;
        logic                   tx_srv;
        logic                   tx_ie;
        logic                   txd;
        tsc_rx_state_t          rx_st;
        logic [BYTE_W-1:0]      rx_shift;
        logic [2:0]             rx_bits;
        logic [CNT_W-1:0]       rx_cnt;
        logic [BYTE_W-1:0]      rx_data;
        logic                   rx_valid;
        logic                   rx_req;
        logic                   rx_ie;
        logic                   rd_run;
        logic                   rd_stop_pend;
        logic                   rxd_s1;
        logic                   rxd_s2;
        logic                   rxd_prev;
        logic                   onl_s1;
        logic                   onl_s2;
    } tsc_state_t;

    tsc_state_t  s_reg;
    tsc_state_t  s_next;
    tsc_status_t status;

    logic              req_new;
    logic [1:0]        op;
    logic [7:0]        stn;
    logic [7:0]        rx_stn;
    logic [7:0]        cmd;
    logic              hit_tx;
    logic              hit_rx;
    logic              wr_byte;
    logic              tx_dout;
    logic              rx_din;
    logic              cmd_rx_ok;
    logic              rx_fall;

    // Address decode; the receiver sits one above the transmitter.
    assign req_new = wb_cyc_i && wb_stb_i && !s_reg.ack && !s_reg.err;
    assign op      = wb_adr_i[ADR_OP_LSB +: 2];
    assign stn     = wb_adr_i[ADR_STN_LSB +: 8];
    assign rx_stn  = 8'(STATION + STN_RX_OFS);                      // R03
    assign hit_tx  = (stn == STATION);                               // R03
    assign hit_rx  = (stn == rx_stn);                                // R03
    assign cmd     = wb_dat_i[BYTE_W-1:0];                          // R20
    assign wr_byte = wb_we_i && wb_sel_i[0];
    assign tx_dout = (op == OP_DATA) && wr_byte && hit_tx;
    assign rx_din  = (op == OP_DATA) && !wb_we_i && hit_rx;
    assign rx_fall = s_reg.onl_s2 && s_reg.rxd_prev && !s_reg.rxd_s2;   // R27

    // Valid receiver command words.
    always_comb begin
        case (cmd)
            CMD_START, CMD_STOP, CMD_INH, CMD_START_INH,
            CMD_STOP_INH, CMD_ALLOW, CMD_START_ALW, CMD_STOP_ALW: cmd_rx_ok = 1'b1;   // R22
            default: cmd_rx_ok = 1'b0;
        endcase
    end

    // Status byte shows the live state of both sections.
    always_comb begin
        status.online     = s_reg.onl_s2;
        status.reader_run = s_reg.rd_run;
        status.tx_busy    = (s_reg.tx_st == TX_SEND);
        status.tx_ie      = s_reg.tx_ie;
        status.tx_srv     = s_reg.tx_srv;
        status.rx_ie      = s_reg.rx_ie;
        status.rx_req     = s_reg.rx_req;
        status.rx_valid   = s_reg.rx_valid;
    end

    // Next state: bus operations first, then the engines, so hardware sets win.
    always_comb begin
        s_next        = s_reg;
        s_next.ack    = 1'b0;
        s_next.rxd_s1 = rxd;
        s_next.rxd_s2 = s_reg.rxd_s1;
        s_next.rxd_prev = s_reg.rxd_s2;
        s_next.onl_s1 = online;
        s_next.onl_s2 = s_reg.onl_s1;

        if (req_new) begin
            if (tx_dout) begin
                if (s_reg.onl_s2 && s_reg.tx_st == TX_IDLE) begin                  // R05 R18
                    s_next.ack      = 1'b1;
                    s_next.tx_shift = {STOP_UNITS, cmd, LINE_SPACE};               // R26 R24
                    s_next.tx_st    = TX_SEND;
                    s_next.tx_unit  = '0;
                    s_next.tx_cnt   = BIT_LOAD;
                    s_next.tx_srv   = 1'b0;                                        // R09 R10
                end
            end else if (rx_din) begin
                if (s_reg.rx_valid) begin                                          // R14 R17
                    s_next.ack      = 1'b1;
                    s_next.dat      = s_reg.rx_data;                               // R02 R24
                    s_next.rx_valid = 1'b0;                                        // R25
                    s_next.rx_req   = 1'b0;                                        // R25
                end
            end else if (op == OP_CTRL && wr_byte && hit_rx) begin
                if (cmd_rx_ok) begin                                               // R19
                    s_next.ack = 1'b1;
                    if (cmd[CB_START]) begin                                       // R04 R22
                        s_next.rd_run       = 1'b1;
                        s_next.rd_stop_pend = 1'b0;
                    end
                    if (cmd[CB_STOP]) begin
                        s_next.rd_stop_pend = 1'b1;                                // R23
                    end
                    if (cmd[CB_INH]) begin
                        s_next.rx_ie = 1'b0;                                       // R06
                    end
                    if (cmd[CB_ALLOW]) begin
                        s_next.rx_ie = 1'b1;                                       // R06
                    end
                end
            end else if (op == OP_CTRL && wr_byte && hit_tx) begin
                if (cmd == CMD_INH || cmd == CMD_ALLOW) begin                      // R19
                    s_next.ack   = 1'b1;
                    s_next.tx_ie = (cmd == CMD_ALLOW);                             // R08 R11
                end
            end else if (op == OP_ADDR && !wb_we_i && (hit_tx || hit_rx)) begin
                if (s_reg.rx_ie && s_reg.rx_req) begin                             // R16
                    s_next.ack    = 1'b1;
                    s_next.dat    = rx_stn;
                    s_next.rx_req = 1'b0;                                          // R12
                end else if (s_reg.tx_ie && s_reg.tx_srv) begin                    // R18
                    s_next.ack    = 1'b1;
                    s_next.dat    = STATION;
                    s_next.tx_srv = 1'b0;                                          // R09
                end
            end else if (op == OP_STAT && !wb_we_i && (hit_tx || hit_rx)) begin
                s_next.ack = 1'b1;
                s_next.dat = status;
            end
        end
        s_next.err = req_new && !s_next.ack;

        // Transmitter: shift the frame out one unit per bit period.
        case (s_reg.tx_st)
            TX_IDLE: begin
                s_next.txd = LINE_MARK;                                            // R01
            end
            TX_SEND: begin
                s_next.txd = s_reg.tx_shift[0];                                    // R26
                if (s_reg.tx_cnt == '0) begin
                    s_next.tx_cnt   = BIT_LOAD;                                    // R01
                    s_next.tx_shift = {LINE_MARK, s_reg.tx_shift[FRAME_UNITS-1:1]};
                    if (s_reg.tx_unit == TX_SRV_UNIT) begin
                        s_next.tx_srv = 1'b1;                                      // R15
                    end
                    if (s_reg.tx_unit == TX_LAST_UNIT) begin
                        s_next.tx_st = TX_IDLE;
                    end else begin
                        s_next.tx_unit = 4'(s_reg.tx_unit + 4'h1);
                    end
                end else begin
                    s_next.tx_cnt = CNT_W'(s_reg.tx_cnt - 1'b1);
                end
            end
            default: begin
                s_next.tx_st = TX_IDLE;
            end
        endcase

        // Receiver: find the start edge, then sample the start and data units at mid-point.
        case (s_reg.rx_st)
            RX_IDLE: begin
                if (rx_fall) begin                                                 // R04 R27
                    s_next.rx_st    = RX_START;
                    s_next.rx_cnt   = HALF_LOAD;
                    s_next.rx_valid = 1'b0;                                        // R13
                    s_next.rx_req   = 1'b0;                                        // R12
                end
            end
            RX_START: begin
                if (s_reg.rx_cnt == '0) begin
                    s_next.rx_st   = (s_reg.rxd_s2 == LINE_SPACE) ? RX_DATA : RX_IDLE;   // R27
                    s_next.rx_cnt  = BIT_LOAD;
                    s_next.rx_bits = '0;
                end else begin
                    s_next.rx_cnt = CNT_W'(s_reg.rx_cnt - 1'b1);
                end
            end
            RX_DATA: begin
                if (s_reg.rx_cnt == '0) begin
                    s_next.rx_shift = {s_reg.rxd_s2, s_reg.rx_shift[BYTE_W-1:1]};  // R26
                    s_next.rx_cnt   = BIT_LOAD;
                    if (s_reg.rx_bits == RX_LAST_BIT) begin
                        s_next.rx_st = RX_STOP;
                    end else begin
                        s_next.rx_bits = 3'(s_reg.rx_bits + 3'h1);
                    end
                end else begin
                    s_next.rx_cnt = CNT_W'(s_reg.rx_cnt - 1'b1);
                end
            end
            RX_STOP: begin
                if (s_reg.rx_cnt == '0) begin
                    s_next.rx_st    = RX_IDLE;
                    s_next.rx_data  = s_reg.rx_shift;                              // R21
                    s_next.rx_valid = 1'b1;                                        // R17
                    s_next.rx_req   = 1'b1;                                        // R12
                    if (s_reg.rd_stop_pend) begin
                        s_next.rd_run       = 1'b0;                                // R23
                        s_next.rd_stop_pend = 1'b0;
                    end
                end else begin
                    s_next.rx_cnt = CNT_W'(s_reg.rx_cnt - 1'b1);
                end
            end
            default: begin
                s_next.rx_st = RX_IDLE;
            end
        endcase
    end

    // State register; reset suppresses requests and parks the reader.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg              <= '0;                                              // R07
            s_reg.tx_st        <= TX_IDLE;
            s_reg.rx_st        <= RX_IDLE;
            s_reg.tx_srv       <= 1'b1;                                            // R08
            s_reg.tx_shift     <= '1;
            s_reg.txd          <= LINE_MARK;
            s_reg.rxd_s1       <= LINE_MARK;
            s_reg.rxd_s2       <= LINE_MARK;
            s_reg.rxd_prev     <= LINE_MARK;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs; each request is gated by its section's own mode.
    assign wb_ack_o   = s_reg.ack;
    assign wb_err_o   = s_reg.err;
    assign wb_dat_o   = {DAT_PAD, s_reg.dat};
    assign txd        = s_reg.txd;
    assign reader_run = s_reg.rd_run;
    assign rx_irq     = s_reg.rx_ie && s_reg.rx_req;                               // R06 R16
    assign tx_irq     = s_reg.tx_ie && s_reg.tx_srv;                               // R06 R11

    // Checks on the live behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_tx_allow_irq;
        req_new && wr_byte && hit_tx && op == OP_CTRL && cmd == CMD_ALLOW && s_reg.tx_srv
            |=> tx_irq && wb_ack_o;
    endproperty
    a_tx_allow_irq: assert property (p_tx_allow_irq) else $error("allow did not raise tx irq"); // R08

    property p_dout_clears;
        req_new && tx_dout && s_reg.tx_st == TX_IDLE && s_reg.onl_s2 |=> wb_ack_o && !tx_irq;
    endproperty
    a_dout_clears: assert property (p_dout_clears) else $error("data-out left tx irq"); // R09

    property p_tx_busy_refuse;
        req_new && tx_dout && s_reg.tx_st == TX_SEND |=> wb_err_o && !wb_ack_o;
    endproperty
    a_tx_busy_refuse: assert property (p_tx_busy_refuse) else $error("busy tx took data"); // R05

    property p_tx_srv_unit;
        s_reg.tx_st == TX_SEND && s_reg.tx_cnt == '0 && s_reg.tx_unit == TX_SRV_UNIT && s_reg.tx_ie
            && !req_new |=> tx_irq;
    endproperty
    a_tx_srv_unit: assert property (p_tx_srv_unit) else $error("no tx irq after unit 9"); // R15

    property p_tx_start_unit;
        $rose(s_reg.tx_st == TX_SEND) |=> txd == LINE_SPACE;
    endproperty
    a_tx_start_unit: assert property (p_tx_start_unit) else $error("frame lacks start unit"); // R26

    property p_din_empty;
        req_new && rx_din && !s_reg.rx_valid |=> wb_err_o && !wb_ack_o;
    endproperty
    a_din_empty: assert property (p_din_empty) else $error("empty data-in acknowledged"); // R14

    property p_din_clears;
        req_new && rx_din && s_reg.rx_valid && s_reg.rx_st != RX_STOP
            |=> wb_ack_o && !rx_irq && !s_reg.rx_valid && wb_dat_o[BYTE_W-1:0] == $past(s_reg.rx_data);
    endproperty
    a_din_clears: assert property (p_din_clears) else $error("data-in did not clear rx"); // R25

    property p_cmd_ack;
        req_new && wr_byte && op == OP_CTRL && hit_rx && cmd_rx_ok |=> wb_ack_o;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("valid command not acknowledged"); // R19

    property p_next_discard;
        s_reg.rx_st == RX_IDLE && rx_fall && !req_new |=> !s_reg.rx_valid && !rx_irq;
    endproperty
    a_next_discard: assert property (p_next_discard) else $error("old byte kept past start"); // R13

    property p_rx_inh_quiet;
        s_reg.rx_st == RX_STOP && s_reg.rx_cnt == '0 && !s_reg.rx_ie && !req_new
            |=> s_reg.rx_valid && !rx_irq;
    endproperty
    a_rx_inh_quiet: assert property (p_rx_inh_quiet) else $error("inhibited rx raised irq"); // R16

    c_tx_irq: cover property ($rose(tx_irq));
    c_rx_byte: cover property ($rose(s_reg.rx_valid));
    c_din_ack: cover property (req_new && rx_din ##1 wb_ack_o);
    c_reader_stop: cover property ($fell(reader_run));

endmodule // tsc_ctrl

// file: core/tsc_pkg.sv
/*
 * Shared constants and types for the teleprinter serial controller.
 * Assumes a single 125 MHz clock and a classic Wishbone master with 32-bit data.
 */
package tsc_pkg;

    // Clock and line rate; the bit period is derived from them.
    localparam int unsigned CLK_HZ         = 125_000_000;
    localparam int unsigned BAUD_RATE      = 110;
    localparam int unsigned BIT_CYCLES_DEF = CLK_HZ / BAUD_RATE;
    localparam int unsigned CNT_W          = 21;

    // Frame layout: one start unit, eight data bits, two stop units.
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned FRAME_UNITS  = 11;
    localparam logic [3:0]  TX_SRV_UNIT  = 4'h8;   // Index of unit 9, the eighth data bit.
    localparam logic [3:0]  TX_LAST_UNIT = 4'hA;
    localparam logic [2:0]  RX_LAST_BIT  = 3'h7;
    localparam logic        LINE_MARK    = 1'b1;
    localparam logic        LINE_SPACE   = 1'b0;
    localparam logic [1:0]  STOP_UNITS   = 2'h3;

    // Wishbone address fields: station in [11:4], operation in [3:2].
    localparam int unsigned ADR_W       = 12;
    localparam int unsigned ADR_OP_LSB  = 2;
    localparam int unsigned ADR_STN_LSB = 4;
    localparam logic [1:0]  OP_DATA     = 2'h0;
    localparam logic [1:0]  OP_CTRL     = 2'h1;
    localparam logic [1:0]  OP_ADDR     = 2'h2;
    localparam logic [1:0]  OP_STAT     = 2'h3;
    localparam logic [7:0]  STATION_DEF = 8'h02;
    localparam logic [7:0]  STN_RX_OFS  = 8'h01;
    localparam logic [23:0] DAT_PAD     = 24'h000000;

    // Command words and the bit that carries each action.
    localparam logic [7:0]  CMD_START     = 8'h01;
    localparam logic [7:0]  CMD_STOP      = 8'h02;
    localparam logic [7:0]  CMD_INH       = 8'h04;
    localparam logic [7:0]  CMD_START_INH = 8'h05;
    localparam logic [7:0]  CMD_STOP_INH  = 8'h06;
    localparam logic [7:0]  CMD_ALLOW     = 8'h08;
    localparam logic [7:0]  CMD_START_ALW = 8'h09;
    localparam logic [7:0]  CMD_STOP_ALW  = 8'h0A;
    localparam int unsigned CB_START      = 0;
    localparam int unsigned CB_STOP       = 1;
    localparam int unsigned CB_INH        = 2;
    localparam int unsigned CB_ALLOW      = 3;

    // One-hot state codes.
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } tsc_tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } tsc_rx_state_t;

    // Status byte read at the status operation.
    typedef struct packed {
        logic online;
        logic reader_run;
        logic tx_busy;
        logic tx_ie;
        logic tx_srv;
        logic rx_ie;
        logic rx_req;
        logic rx_valid;
    } tsc_status_t;

endpackage

// file: test/tsc_term.sv
/* Terminal model: sends keyboard frames on rxd and decodes frames seen on txd.
   Assumes the controller's clock and a unit of BIT_CYCLES clock cycles. */
`timescale 1ns/1ps

module tsc_term
    import tsc_pkg::*;
#(
    parameter int unsigned BIT_CYCLES = 16
) (
    input  wire logic       clk,
    input  wire logic       txd,
    output logic            rxd,
    output logic [7:0]      tx_seen
);
    // Decodes each transmit frame mid-unit, least significant bit first.
    initial begin
        rxd = LINE_MARK;
        tx_seen = 8'h00;
        forever begin
            @(negedge txd);
            repeat (BIT_CYCLES / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge clk);
                tx_seen[i] = txd;
            end
            repeat (BIT_CYCLES) @(posedge clk);
        end
    end

    // Sends one frame and leaves the line at mark afterwards.
    task automatic send_char(input logic [7:0] b);
        logic [10:0] frame;
        frame = {2'b11, b, LINE_SPACE};
        for (int i = 0; i < 11; i++) begin
            rxd <= frame[i];
            repeat (BIT_CYCLES) @(posedge clk);
        end
    endtask
endmodule // tsc_term

// file: test/tb.sv
/* Self-checking bench for the teleprinter serial controller.
   Assumes the terminal model in tsc_term.sv and a short unit of 16 cycles. */
`timescale 1ns/1ps

module tb;
    import tsc_pkg::*;
    localparam int unsigned BC  = 16;
    localparam logic [11:0] TXA = {STATION_DEF, 4'h0};
    localparam logic [11:0] RXA = {STATION_DEF + STN_RX_OFS, 4'h0};
    logic        clk, rst, cyc, stb, we, ack, err, ok;
    logic        rx_irq, tx_irq, txd, rxd, online, reader_run;
    logic [11:0] adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  seen, q;
    int          err_count, num_checks;

    tsc_ctrl #(.BIT_CYCLES(BC), .STATION(STATION_DEF)) i_tsc_ctrl (
        .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .rx_irq(rx_irq), .tx_irq(tx_irq),
        .txd(txd), .rxd(rxd), .online(online), .reader_run(reader_run));
    tsc_term #(.BIT_CYCLES(BC)) i_tsc_term (.clk(clk), .txd(txd), .rxd(rxd), .tx_seen(seen));

    // Widens a flag for the byte compare.
    function automatic logic [7:0] b1(input logic x);
        return {7'h00, x};
    endfunction

    // Compares one byte-sized result.
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One classic bus cycle; ok is set on ack and cleared on err; the watchdog ends a hang.
    task automatic wb(input logic [11:0] a, input logic [1:0] op, input logic w,
                      input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a | {8'h00, op, 2'b00};
        wdat <= {DAT_PAD, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1 && err !== 1'b1);
        ok = ack;
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    // Reset state, allow release, data-out, busy refusal and address-in.
    task automatic t_tx1();
        check("irqs", 8'h00, {6'h00, rx_irq, tx_irq});
        check("reader", 8'h00, b1(reader_run));
        wb(TXA, OP_CTRL, 1'b1, CMD_ALLOW);
        check("tx_irq_rel", 8'h01, b1(tx_irq));
        wb(TXA, OP_DATA, 1'b1, 8'hA5);
        check("dout_ack", 8'h01, b1(ok));
        check("tx_irq_dout", 8'h00, b1(tx_irq));
        wb(TXA, OP_DATA, 1'b1, 8'h5A);
        check("dout_busy", 8'h00, b1(ok));
        repeat (8 * BC) @(posedge clk);
        check("tx_irq_early", 8'h00, b1(tx_irq));
        repeat (2 * BC) @(posedge clk);
        check("tx_irq_unit9", 8'h01, b1(tx_irq));
        repeat (2 * BC) @(posedge clk);
        check("tx_byte", 8'hA5, seen);
        wb(TXA, OP_ADDR, 1'b0, 8'h00);
        check("addr_in", STATION_DEF, q);
        check("tx_irq_ain", 8'h00, b1(tx_irq));
        wb(TXA, OP_ADDR, 1'b0, 8'h00);
        check("addr_in_again", 8'h00, b1(ok));
    endtask

    // Inhibit during a frame holds the request back; allow releases it.
    task automatic t_tx2();
        wb(TXA, OP_DATA, 1'b1, 8'h3C);
        wb(TXA, OP_CTRL, 1'b1, CMD_INH);
        check("inh_ack", 8'h01, b1(ok));
        repeat (12 * BC) @(posedge clk);
        check("tx_irq_inh", 8'h00, b1(tx_irq));
        check("tx_byte2", 8'h3C, seen);
        wb(TXA, OP_CTRL, 1'b1, CMD_ALLOW);
        check("tx_irq_alw", 8'h01, b1(tx_irq));
        wb(TXA, OP_ADDR, 1'b0, 8'h00);
        check("addr_in2", STATION_DEF, q);
    endtask

    // Every command, reader start, receive, data-in and stop after one char.
    task automatic t_rx();
        logic [7:0] cmds [8];
        cmds = '{CMD_START, CMD_STOP, CMD_INH, CMD_START_INH, CMD_STOP_INH,
                 CMD_START_ALW, CMD_STOP_ALW, CMD_ALLOW};
        foreach (cmds[i]) begin
            wb(RXA, OP_CTRL, 1'b1, cmds[i]);
            check("cmd_ack", 8'h01, b1(ok));
        end
        wb(RXA, OP_CTRL, 1'b1, CMD_START);
        check("reader_on", 8'h01, b1(reader_run));
        i_tsc_term.send_char(8'hC3);
        repeat (4) @(posedge clk);
        check("rx_irq", 8'h01, b1(rx_irq));
        wb(RXA, OP_DATA, 1'b0, 8'h00);
        check("din", 8'hC3, q);
        check("rx_irq_din", 8'h00, b1(rx_irq));
        wb(RXA, OP_DATA, 1'b0, 8'h00);
        check("din_again", 8'h00, b1(ok));
        wb(RXA, OP_CTRL, 1'b1, CMD_STOP);
        check("reader_hold", 8'h01, b1(reader_run));
        i_tsc_term.send_char(8'h80);
        repeat (4) @(posedge clk);
        check("reader_off", 8'h00, b1(reader_run));
    endtask

    // A new start edge discards the unread byte and withdraws the request.
    task automatic t_over();
        fork
            i_tsc_term.send_char(8'h82);
            begin
                repeat (3 * BC) @(posedge clk);
                check("rx_irq_drop", 8'h00, b1(rx_irq));
                wb(RXA, OP_DATA, 1'b0, 8'h00);
                check("din_overrun", 8'h00, b1(ok));
            end
        join
        repeat (4) @(posedge clk);
        wb(RXA, OP_ADDR, 1'b0, 8'h00);
        check("ain_rx", STATION_DEF + STN_RX_OFS, q);
        check("rx_irq_ain", 8'h00, b1(rx_irq));
        wb(RXA, OP_DATA, 1'b0, 8'h00);
        check("din_new", 8'h82, q);
    endtask

    // Inhibited receiver: no request, address-in refused, first data-in served.
    task automatic t_noint();
        wb(RXA, OP_CTRL, 1'b1, CMD_INH);
        i_tsc_term.send_char(8'h85);
        repeat (4) @(posedge clk);
        check("rx_irq_inh", 8'h00, b1(rx_irq));
        wb(RXA, OP_ADDR, 1'b0, 8'h00);
        check("ain_inh", 8'h00, b1(ok));
        wb(RXA, OP_DATA, 1'b0, 8'h00);
        check("din_inh", 8'h85, q);
        wb(RXA, OP_DATA, 1'b0, 8'h00);
        check("din_inh2", 8'h00, b1(ok));
        // Status: online, transmitter allowed, everything else clear.
        wb(RXA, OP_STAT, 1'b0, 8'h00);
        check("status", 8'h90, q);
    endtask

    // Free-running clock of 8 ns.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    // Reset, online wait for the synchroniser, then the scenarios.
    initial begin
        err_count = 0;
        num_checks = 0;
        {rst, online} = 2'b11;
        {cyc, stb, we} = 3'b000;
        adr = 12'h000;
        wdat = 32'h00000000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_tx1();
        t_tx2();
        t_rx();
        t_over();
        t_noint();
        report_and_stop();
    end
endmodule // tb
